// ==== rbtf_defines.svh ====
`ifndef RBTF_DEFINES_SVH
`define RBTF_DEFINES_SVH
// Register byte offsets
`define RBTF_A_CFG 8'h00
`define RBTF_A_START_LO 8'h04
`define RBTF_A_START_HI 8'h08
`define RBTF_A_SYM_INC 8'h0c
`define RBTF_A_PRE_LEN 8'h10
`define RBTF_A_PRE_PAT 8'h14
`define RBTF_A_PAYLOAD 8'h18
`define RBTF_A_SLOT 8'h1c
`define RBTF_A_GUARD 8'h20
`define RBTF_A_LATENCY 8'h24
`define RBTF_A_PID 8'h28
`define RBTF_A_STATUS 8'h2c
`define RBTF_A_CNT_LO 8'h30
`define RBTF_A_CNT_HI 8'h34
`define RBTF_A_CAP 8'h38
// Field positions
`define RBTF_CFG_CRC_BIT 3
`define RBTF_ST_UNDER_BIT 4
`define RBTF_ST_REFUSE_BIT 5
`define RBTF_CAP_TS_BIT 20
// Reset values
`define RBTF_RST_SYM_INC 32'h0147ae14
`define RBTF_RST_PRE_LEN 16'h0020
`define RBTF_RST_PRE_PAT 32'hcccc3333
`define RBTF_RST_GUARD 16'h0004
`define RBTF_RST_PID 13'h0000
`define RBTF_RST_CAP 24'h000001
`define RBTF_PRBS_INIT 15'h4a80
`define RBTF_CRC_INIT 16'hffff
`define RBTF_CRC_POLY 16'h1021
// Framing and timing constants
`define RBTF_TS_SYNC 8'h47
`define RBTF_TS_BYTES 188
`define RBTF_CELL_BYTES 53
`define RBTF_REF_MULT 300
`define RBTF_REF_HZ 27000000
`define RBTF_CLK_HZ 200000000
`endif

// ==== rbtf_framer.sv ====
`timescale 1ns/1ps
`include "rbtf_defines.svh"
// Overview of operation
// - Take reference samples from configured PID
// - Reference counter ticks at 27 MHz
// - Superframe starts at programmed counter value
// - Compare counter, start when equal
// - Start error within half a symbol
// - Start resolution one counter tick
// - Schedule against ideal delay-free counter
// - Terminal adds receiver latency compensation
// - Symbol clock within 20 ppm
// - Per-symbol jitter below 1/20 symbol
// - Plan gives start values and offsets
// - Slot tables give timing and duration
// - Five burst kinds supported
// - Cell burst: prefix plus 53-byte cells
// - Packet burst: 188-byte packets
// - Packet count from slot minus overhead
// - Packet support advertised at logon
// - Maintenance: preamble, optional access field
// - Optional CRC after randomizing access field
// - Guard time after traffic and maintenance
// - Maintenance bursts allowed in contention
// - Acquisition: table preamble, guard both sides
// - Scramble data, reload PRBS per burst
// - Capability bit 20 flags packet support
module rbtf_framer #(
    parameter int CNT_W = 42,
    parameter bit TS_SUPPORT = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Forward transport stream pins
    input wire logic ts_clk,
    input wire logic ts_start,
    input wire logic [7:0] ts_data,
    // Payload byte source
    input wire logic [7:0] din_byte,
    input wire logic din_valid,
    output logic din_ready,
    // Serial burst output
    output logic tx_bit,
    output logic tx_valid,
    output logic tx_on,
    output logic burst_busy
);
    localparam logic [8:0] TICK_INC = 9'(`RBTF_REF_HZ / 1000000);
    localparam logic [8:0] TICK_MOD = 9'(`RBTF_CLK_HZ / 1000000);

    // Counter must hold 33-bit base times 300 plus extension
    if (CNT_W != 42) begin : g_bad_width
        $error("rbtf_framer: CNT_W must be 42");
    end

    // Link pin synchronisers: three flops, clock changes when 2nd and 3rd agree
    logic [9:0] p1_q, p2_q, p3_q;
    logic lck_q, lck_d, ledge;
    always_comb begin
        lck_d = (p2_q[9] == p3_q[9]) ? p3_q[9] : lck_q;
        ledge = lck_d & ~lck_q;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            p1_q <= '0;
            p2_q <= '0;
            p3_q <= '0;
            lck_q <= 1'b0;
        end else if (clk_en) begin
            p1_q <= {ts_clk, ts_start, ts_data};
            p2_q <= p1_q;
            p3_q <= p2_q;
            lck_q <= lck_d;
        end
    end

    // Register file state
    logic [3:0] cfg_q, cfg_d;
    logic [41:0] start_q, start_d;
    logic [31:0] inc_q, inc_d, pat_q, pat_d;
    logic [15:0] plen_q, plen_d, pay_q, pay_d, slot_q, slot_d;
    logic [15:0] ovh_q, ovh_d, guard_q, guard_d, lat_q, lat_d;
    logic [7:0] pfx_q, pfx_d;
    logic [12:0] pid_q, pid_d;
    logic [23:0] cap_q, cap_d;
    logic und_q, und_d, ref_q, ref_d, arm_q, arm_d;
    logic [31:0] rd_q, rd_d;
    // Events from the sequencer, set wins over clear
    logic und_set, ref_set, lock_q, lock_d;
    logic [2:0] st_code;
    logic [41:0] nc_q, nc_d;

    // Register writes and read mux
    always_comb begin
        cfg_d = cfg_q;
        start_d = start_q;
        inc_d = inc_q;
        pat_d = pat_q;
        plen_d = plen_q;
        pay_d = pay_q;
        pfx_d = pfx_q;
        slot_d = slot_q;
        ovh_d = ovh_q;
        guard_d = guard_q;
        lat_d = lat_q;
        pid_d = pid_q;
        cap_d = cap_q;
        und_d = und_q;
        ref_d = ref_q;
        arm_d = 1'b0;
        rd_d = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                `RBTF_A_CFG: cfg_d = reg_wdata[3:0];
                `RBTF_A_START_LO: start_d[31:0] = reg_wdata;
                `RBTF_A_START_HI: begin
                    start_d[41:32] = reg_wdata[9:0];
                    arm_d = 1'b1; // Writing the top half arms
                end
                `RBTF_A_SYM_INC: inc_d = reg_wdata;
                `RBTF_A_PRE_LEN: plen_d = reg_wdata[15:0];
                `RBTF_A_PRE_PAT: pat_d = reg_wdata;
                `RBTF_A_PAYLOAD: {pfx_d, pay_d} = reg_wdata[23:0];
                `RBTF_A_SLOT: {ovh_d, slot_d} = reg_wdata;
                `RBTF_A_GUARD: guard_d = reg_wdata[15:0];
                `RBTF_A_LATENCY: lat_d = reg_wdata[15:0];
                `RBTF_A_PID: pid_d = reg_wdata[12:0];
                `RBTF_A_CAP: cap_d = reg_wdata[23:0];
                `RBTF_A_STATUS: begin
                    // Write one to clear sticky flags
                    und_d = und_q & ~reg_wdata[`RBTF_ST_UNDER_BIT];
                    ref_d = ref_q & ~reg_wdata[`RBTF_ST_REFUSE_BIT];
                end
                default: ;
            endcase
        end
        if (und_set) begin
            und_d = 1'b1;
        end
        if (ref_set) begin
            ref_d = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `RBTF_A_CFG: rd_d = {28'h0, cfg_q};
                `RBTF_A_START_LO: rd_d = start_q[31:0];
                `RBTF_A_START_HI: rd_d = {22'h0, start_q[41:32]};
                `RBTF_A_SYM_INC: rd_d = inc_q;
                `RBTF_A_PRE_LEN: rd_d = {16'h0, plen_q};
                `RBTF_A_PRE_PAT: rd_d = pat_q;
                `RBTF_A_PAYLOAD: rd_d = {8'h0, pfx_q, pay_q};
                `RBTF_A_SLOT: rd_d = {ovh_q, slot_q};
                `RBTF_A_GUARD: rd_d = {16'h0, guard_q};
                `RBTF_A_LATENCY: rd_d = {16'h0, lat_q};
                `RBTF_A_PID: rd_d = {19'h0, pid_q};
                `RBTF_A_CAP: rd_d = {8'h0, cap_q[23:21], TS_SUPPORT, cap_q[19:0]};
                `RBTF_A_STATUS: rd_d = {26'h0, ref_q, und_q, lock_q, st_code};
                `RBTF_A_CNT_LO: rd_d = nc_q[31:0];
                `RBTF_A_CNT_HI: rd_d = {22'h0, nc_q[41:32]};
                default: rd_d = '0;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q <= '0;
            start_q <= '0;
            inc_q <= `RBTF_RST_SYM_INC;
            pat_q <= `RBTF_RST_PRE_PAT;
            plen_q <= `RBTF_RST_PRE_LEN;
            pay_q <= '0;
            pfx_q <= '0;
            slot_q <= '0;
            ovh_q <= '0;
            guard_q <= `RBTF_RST_GUARD;
            lat_q <= '0;
            pid_q <= `RBTF_RST_PID;
            cap_q <= `RBTF_RST_CAP;
            und_q <= 1'b0;
            ref_q <= 1'b0;
            arm_q <= 1'b0;
            rd_q <= '0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
            start_q <= start_d;
            inc_q <= inc_d;
            pat_q <= pat_d;
            plen_q <= plen_d;
            pay_q <= pay_d;
            pfx_q <= pfx_d;
            slot_q <= slot_d;
            ovh_q <= ovh_d;
            guard_q <= guard_d;
            lat_q <= lat_d;
            pid_q <= pid_d;
            cap_q <= cap_d;
            und_q <= und_d;
            ref_q <= ref_d;
            arm_q <= arm_d;
            rd_q <= rd_d;
        end
    end
    assign reg_rdata = rd_q;

    // Forward packet parser: header, adaptation field, reference sample
    logic [3:0] idx_q, idx_d;
    logic [12:0] tpid_q, tpid_d;
    logic [1:0] afc_q, afc_d;
    logic [7:0] afl_q, afl_d;
    logic flg_q, flg_d, ld_q, ld_d;
    logic [47:0] sh_q, sh_d;
    always_comb begin
        idx_d = idx_q;
        tpid_d = tpid_q;
        afc_d = afc_q;
        afl_d = afl_q;
        flg_d = flg_q;
        sh_d = sh_q;
        ld_d = 1'b0;
        if (ledge) begin
            if (p3_q[8] && p3_q[7:0] == `RBTF_TS_SYNC) begin
                idx_d = 4'h1;
            end else if (idx_q != 4'h0 && idx_q != 4'hc) begin
                idx_d = idx_q + 4'h1;
                unique case (idx_q)
                    4'h1: tpid_d[12:8] = p3_q[4:0];
                    4'h2: tpid_d[7:0] = p3_q[7:0];
                    4'h3: afc_d = p3_q[5:4];
                    4'h4: afl_d = p3_q[7:0];
                    4'h5: flg_d = p3_q[4];
                    default: sh_d = {sh_q[39:0], p3_q[7:0]};
                endcase
                // Sample complete after the sixth reference byte
                ld_d = (idx_q == 4'hb) && (tpid_q == pid_q) && afc_q[1] && (afl_q > 8'h06) && flg_q;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            idx_q <= '0;
            tpid_q <= '0;
            afc_q <= '0;
            afl_q <= '0;
            flg_q <= 1'b0;
            sh_q <= '0;
            ld_q <= 1'b0;
        end else if (clk_en) begin
            idx_q <= idx_d;
            tpid_q <= tpid_d;
            afc_q <= afc_d;
            afl_q <= afl_d;
            flg_q <= flg_d;
            sh_q <= sh_d;
            ld_q <= ld_d;
        end
    end

    // Local 27 MHz reference: fractional accumulator on the system clock
    logic [8:0] acc_q, acc_d, acc_sum;
    logic tick;
    always_comb begin
        acc_sum = acc_q + TICK_INC;
        tick = (acc_sum >= TICK_MOD);
        acc_d = tick ? acc_sum - TICK_MOD : acc_sum;
        nc_d = nc_q + {41'h0, tick};
        lock_d = lock_q | ld_q;
        if (ld_q) begin
            // Base times 300 plus extension, plus receiver latency
            nc_d = 42'(sh_q[47:15]) * 42'd`RBTF_REF_MULT + 42'(sh_q[8:0]) + 42'(lat_q);
            acc_d = '0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q <= '0;
            nc_q <= '0;
            lock_q <= 1'b0;
        end else if (clk_en) begin
            acc_q <= acc_d;
            nc_q <= nc_d;
            lock_q <= lock_d;
        end
    end

    // Burst sequencer, symbol timing, scrambler and CRC
    rbtf_pkg::rbtf_state_e st_q, st_d;
    rbtf_pkg::rbtf_kind_e kind;
    logic [31:0] nco_q, nco_d;
    logic [32:0] nco_sum;
    logic sym;
    logic [15:0] cnt_q, cnt_d;
    logic [23:0] tot_q, tot_d, sent_q, sent_d;
    logic [15:0] rem_q, rem_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] cur_q, cur_d, bnow;
    logic [14:0] prbs_q, prbs_d;
    logic [15:0] crc_q, crc_d;
    logic [7:0] buf_q, buf_d;
    logic full_q, full_d, rdy_q, rdy_d, use_buf;
    logic txb_q, txb_d, txv_q, txv_d, txo_q, txo_d, busy_q, busy_d;
    logic sbit, guard_done;
    assign kind = rbtf_pkg::rbtf_kind_e'(cfg_q[2:0]);
    assign st_code = st_q;
    always_comb begin
        st_d = st_q;
        nco_sum = {1'b0, nco_q} + {1'b0, inc_q};
        nco_d = nco_sum[31:0];
        sym = nco_sum[32] && st_q != rbtf_pkg::RBTF_S_IDLE && st_q != rbtf_pkg::RBTF_S_ARMED;
        cnt_d = cnt_q;
        tot_d = tot_q;
        sent_d = sent_q;
        rem_d = rem_q;
        bit_d = bit_q;
        cur_d = cur_q;
        prbs_d = prbs_q;
        crc_d = crc_q;
        txb_d = txb_q;
        txv_d = 1'b0;
        txo_d = txo_q;
        ref_set = 1'b0;
        und_set = 1'b0;
        use_buf = 1'b0;
        guard_done = (cnt_q + 16'h1 >= guard_q);
        // Byte being sent: capability first for logon, else the buffer
        if (kind == rbtf_pkg::RBTF_K_LOGON && sent_q < 24'h3) begin
            unique case (sent_q[1:0])
                2'h0: bnow = {cap_q[23:21], TS_SUPPORT, cap_q[19:16]};
                2'h1: bnow = cap_q[15:8];
                default: bnow = cap_q[7:0];
            endcase
        end else begin
            bnow = full_q ? buf_q : 8'h00;
        end
        if (bit_q != 3'h0) begin
            bnow = cur_q;
        end
        sbit = bnow[3'h7 - bit_q] ^ prbs_q[1] ^ prbs_q[0];
        unique case (st_q)
            rbtf_pkg::RBTF_S_IDLE: begin
                if (arm_q) begin
                    if (cfg_q[2:0] > 3'h4 || (kind == rbtf_pkg::RBTF_K_TSP && !TS_SUPPORT)) begin
                        ref_set = 1'b1;
                    end else begin
                        st_d = rbtf_pkg::RBTF_S_ARMED;
                        rem_d = slot_q - ovh_q;
                        unique case (kind)
                            rbtf_pkg::RBTF_K_CELL: tot_d = 24'(pfx_q) + 24'(pay_q) * 24'd`RBTF_CELL_BYTES;
                            rbtf_pkg::RBTF_K_MAINT: tot_d = 24'(pay_q);
                            rbtf_pkg::RBTF_K_LOGON: tot_d = 24'(pay_q) + 24'h3;
                            default: tot_d = '0; // Acquisition carries no data
                        endcase
                    end
                end
            end
            rbtf_pkg::RBTF_S_ARMED: begin
                // Packet count by repeated subtraction while waiting
                if (kind == rbtf_pkg::RBTF_K_TSP && rem_q >= 16'd`RBTF_TS_BYTES) begin
                    rem_d = rem_q - 16'd`RBTF_TS_BYTES;
                    tot_d = tot_q + 24'd`RBTF_TS_BYTES;
                end
                if (nc_q == start_q) begin
                    // Preset so the first symbol strobes next cycle
                    nco_d = 32'h0 - inc_q;
                    cnt_d = '0;
                    sent_d = '0;
                    bit_d = '0;
                    prbs_d = `RBTF_PRBS_INIT;
                    crc_d = `RBTF_CRC_INIT;
                    st_d = (kind == rbtf_pkg::RBTF_K_ACQ) ? rbtf_pkg::RBTF_S_LEAD : rbtf_pkg::RBTF_S_PRE;
                end
            end
            rbtf_pkg::RBTF_S_LEAD: begin
                if (sym) begin
                    cnt_d = cnt_q + 16'h1;
                    if (guard_done) begin
                        cnt_d = '0;
                        st_d = rbtf_pkg::RBTF_S_PRE;
                    end
                end
            end
            rbtf_pkg::RBTF_S_PRE: begin
                if (sym) begin
                    txb_d = pat_q[5'h1f - cnt_q[4:0]];
                    txv_d = 1'b1;
                    txo_d = 1'b1;
                    cnt_d = cnt_q + 16'h1;
                    if (cnt_q + 16'h1 >= plen_q) begin
                        cnt_d = '0;
                        st_d = (tot_q != 24'h0) ? rbtf_pkg::RBTF_S_DATA : rbtf_pkg::RBTF_S_GUARD;
                    end
                end
            end
            rbtf_pkg::RBTF_S_DATA: begin
                if (sym) begin
                    if (bit_q == 3'h0 && !(kind == rbtf_pkg::RBTF_K_LOGON && sent_q < 24'h3)) begin
                        use_buf = full_q;
                        und_set = ~full_q; // Starved source sends zeros
                    end
                    cur_d = bnow;
                    txb_d = sbit;
                    txv_d = 1'b1;
                    prbs_d = {prbs_q[1] ^ prbs_q[0], prbs_q[14:1]};
                    // CRC covers the randomized bits
                    crc_d = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ sbit) ? `RBTF_CRC_POLY : 16'h0);
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        sent_d = sent_q + 24'h1;
                        if (sent_q + 24'h1 >= tot_q) begin
                            st_d = (kind == rbtf_pkg::RBTF_K_MAINT && cfg_q[`RBTF_CFG_CRC_BIT])
                                ? rbtf_pkg::RBTF_S_CRC : rbtf_pkg::RBTF_S_GUARD;
                        end
                    end
                end
            end
            rbtf_pkg::RBTF_S_CRC: begin
                if (sym) begin
                    txb_d = crc_q[15];
                    txv_d = 1'b1;
                    crc_d = {crc_q[14:0], 1'b0};
                    cnt_d = cnt_q + 16'h1;
                    if (cnt_q == 16'hf) begin
                        cnt_d = '0;
                        st_d = rbtf_pkg::RBTF_S_GUARD;
                    end
                end
            end
            rbtf_pkg::RBTF_S_GUARD: begin
                if (sym) begin
                    // Last symbol keeps power to its end, ramp-down fills the guard
                    txo_d = 1'b0;
                    cnt_d = cnt_q + 16'h1;
                    // First strobe here only ends the last symbol, so it is not a guard symbol
                    if (cnt_q != 16'h0 && cnt_q >= guard_q) begin
                        cnt_d = '0;
                        st_d = rbtf_pkg::RBTF_S_IDLE;
                    end
                end
            end
            default: st_d = rbtf_pkg::RBTF_S_IDLE;
        endcase
        busy_d = (st_d != rbtf_pkg::RBTF_S_IDLE);
        // One-byte holding buffer, ready only while empty
        full_d = (full_q & ~use_buf) | (rdy_q & din_valid);
        buf_d = (rdy_q & din_valid) ? din_byte : buf_q;
        rdy_d = ~full_d;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= rbtf_pkg::RBTF_S_IDLE;
            nco_q <= '0;
            cnt_q <= '0;
            tot_q <= '0;
            sent_q <= '0;
            rem_q <= '0;
            bit_q <= '0;
            cur_q <= '0;
            prbs_q <= `RBTF_PRBS_INIT;
            crc_q <= `RBTF_CRC_INIT;
            buf_q <= '0;
            full_q <= 1'b0;
            rdy_q <= 1'b0;
            txb_q <= 1'b0;
            txv_q <= 1'b0;
            txo_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            nco_q <= nco_d;
            cnt_q <= cnt_d;
            tot_q <= tot_d;
            sent_q <= sent_d;
            rem_q <= rem_d;
            bit_q <= bit_d;
            cur_q <= cur_d;
            prbs_q <= prbs_d;
            crc_q <= crc_d;
            buf_q <= buf_d;
            full_q <= full_d;
            rdy_q <= rdy_d;
            txb_q <= txb_d;
            txv_q <= txv_d;
            txo_q <= txo_d;
            busy_q <= busy_d;
        end
    end
    assign din_ready = rdy_q;
    assign tx_bit = txb_q;
    assign tx_valid = txv_q;
    assign tx_on = txo_q;
    assign burst_busy = busy_q;
endmodule : rbtf_framer

// ==== rbtf_framer_asserts.sv ====
`timescale 1ns/1ps
module rbtf_framer_asserts #(
    parameter int CNT_W = 42,
    parameter bit TS_SUPPORT = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Payload source
    input wire logic [7:0] din_byte,
    input wire logic din_valid,
    input wire logic din_ready,
    // Serial output
    input wire logic tx_bit,
    input wire logic tx_valid,
    input wire logic tx_on,
    input wire logic burst_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Read request at a given address
    sequence s_rd(logic [7:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence
    // Data stands only in the cycle after a read
    chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
    chk_cap_bit: assert property (s_rd(8'h38) |=> reg_rdata[20] == TS_SUPPORT) else $error("cap bit wrong");
    chk_unmapped_zero: assert property (s_rd(8'hfc) |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    chk_power_busy: assert property (tx_on |-> burst_busy) else $error("power on while idle");
    chk_symbol_power: assert property (tx_valid |-> tx_on && burst_busy) else $error("symbol without power");
    // Power must already be off when the burst ends: guard closes every burst
    chk_guard_tail: assert property ($fell(burst_busy) |-> !$past(tx_on)) else $error("no guard at end");
    chk_release_quiet: assert property ($rose(rst_n) |-> !burst_busy && !tx_on && !din_ready)
        else $error("outputs active after reset");
    chk_ready_drop: assert property (clk_en && din_valid && din_ready |=> !din_ready) else $error("ready held");
    cov_burst: cover property ($fell(burst_busy));
endmodule : rbtf_framer_asserts

bind rbtf_framer rbtf_framer_asserts #(.CNT_W(CNT_W), .TS_SUPPORT(TS_SUPPORT)) chk_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .din_byte(din_byte), .din_valid(din_valid), .din_ready(din_ready), .tx_bit(tx_bit),
    .tx_valid(tx_valid), .tx_on(tx_on), .burst_busy(burst_busy));

// ==== rbtf_pkg.sv ====
package rbtf_pkg;
    // Burst kinds as written to the config register
    typedef enum logic [2:0] {
        RBTF_K_CELL = 3'h0,
        RBTF_K_TSP = 3'h1,
        RBTF_K_MAINT = 3'h2,
        RBTF_K_ACQ = 3'h3,
        RBTF_K_LOGON = 3'h4
    } rbtf_kind_e;
    // Burst sequencer, Gray from IDLE through ARMED, LEAD, PRE, DATA and CRC to GUARD
    typedef enum logic [2:0] {
        RBTF_S_IDLE = 3'h0,
        RBTF_S_ARMED = 3'h1,
        RBTF_S_LEAD = 3'h3,
        RBTF_S_PRE = 3'h2,
        RBTF_S_DATA = 3'h6,
        RBTF_S_CRC = 3'h7,
        RBTF_S_GUARD = 3'h5
    } rbtf_state_e;
endpackage : rbtf_pkg

// ==== rbtf_stream_src.sv ====
`timescale 1ns/1ps
module rbtf_stream_src (
    // Forward stream pins
    output logic ts_clk,
    output logic ts_start,
    output logic [7:0] ts_data
);
    initial begin
        ts_clk = 1'b0;
        ts_start = 1'b0;
        ts_data = 8'hb8;
    end
    // One reference packet head; byte clock runs only inside it
    task automatic send(input logic [12:0] pid, input logic [32:0] base, input logic [8:0] ext);
        logic [7:0] b [12];
        b = '{8'h47, {3'h0, pid[12:8]}, pid[7:0], 8'h20, 8'h07, 8'h10, base[32:25], base[24:17], base[16:9],
            base[8:1], {base[0], 6'h3f, ext[8]}, ext[7:0]};
        for (int i = 0; i < 12; i++) begin
            ts_start = (i == 0);
            ts_data = b[i];
            #40 ts_clk = 1'b1;
            #40 ts_clk = 1'b0;
        end
        // Released lines show no stale byte
        ts_start = 1'b0;
        ts_data = ~b[11];
    endtask : send
endmodule : rbtf_stream_src

// ==== return_burst_timing_framer_tb_top.sv ====
`timescale 1ns/1ps
module return_burst_timing_framer_tb_top;
    logic clk_sys, rst_n, clk_en, reg_wr, reg_rd, din_valid, din_ready, tx_bit, tx_valid, tx_on, burst_busy;
    logic ts_clk, ts_start;
    logic [7:0] reg_addr, ts_data, din_byte;
    logic [31:0] reg_wdata, reg_rdata, v;
    int fail_count = 0;
    int samples_checked = 0;
    rbtf_framer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ts_clk(ts_clk),
        .ts_start(ts_start), .ts_data(ts_data), .din_byte(din_byte), .din_valid(din_valid), .din_ready(din_ready),
        .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_on(tx_on), .burst_busy(burst_busy));
    rbtf_stream_src src_u (.ts_clk(ts_clk), .ts_start(ts_start), .ts_data(ts_data));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Arm a burst 300 ticks ahead and collect its symbols until busy drops
    task automatic burst(input logic [31:0] cfg, output int n, output logic [15:0] bits);
        wr(8'h00, cfg);
        rd(8'h30, v);
        wr(8'h04, v + 32'd300);
        wr(8'h08, 32'h0);
        n = 0;
        for (int c = 0; c < 8000 && (n == 0 || burst_busy); c++) begin
            @(posedge clk_sys);
            #1;
            if (tx_valid === 1'b1) begin
                bits = {bits[14:0], tx_bit};
                n++;
            end
        end
    endtask : burst
    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // Watchdog well beyond the expected run of about 60 us
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    initial begin
        static logic [7:0] ra [6] = '{8'h0c, 8'h10, 8'h14, 8'h20, 8'h38, 8'hfc};
        static logic [31:0] rv [6] = '{32'h0147ae14, 32'h20, 32'hcccc3333, 32'h4, 32'h0010_0001, 32'h0};
        logic [14:0] s;
        logic [15:0] bits, exp_bits;
        int n;
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        din_byte = 8'ha5;
        din_valid = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, capability and an unmapped place
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], v);
            chk("reset value", v, rv[i]);
        end
        // Reference packet loads the counter as base*300+ext
        wr(8'h28, 32'h0123);
        src_u.send(13'h0123, 33'd1000, 9'd5);
        repeat (10) @(posedge clk_sys);
        rd(8'h30, v);
        chk("counter window", 32'(v >= 32'd300005 && v < 32'd300025), 32'h1);
        rd(8'h2c, v);
        chk("locked", 32'(v[3]), 32'h1);
        // Unsupported kind is refused, then cleared
        wr(8'h00, 32'h5);
        wr(8'h08, 32'h0);
        rd(8'h2c, v);
        chk("refused", 32'(v[5]), 32'h1);
        wr(8'h2c, 32'h20);
        rd(8'h2c, v);
        chk("refused clear", 32'(v[5]), 32'h0);
        // Maintenance burst: 8 preamble symbols, one scrambled byte, guard
        wr(8'h10, 32'h8);
        wr(8'h18, 32'h1);
        din_valid <= 1'b1;
        burst(32'h2, n, bits);
        // Randomizer sequence from the reload value, output SR14 xor SR15
        s = 15'h4a80;
        exp_bits = 16'hcca5;
        for (int i = 7; i >= 0; i--) begin
            exp_bits[i] = exp_bits[i] ^ s[1] ^ s[0];
            s = {s[1] ^ s[0], s[14:1]};
        end
        chk("symbol count", 32'(n), 32'd16);
        chk("burst bits", 32'(bits), 32'(exp_bits));
        chk("busy after guard", 32'(burst_busy), 32'h0);
        // Acquisition: lead guard, bare preamble, trailing guard
        burst(32'h3, n, bits);
        chk("acquisition count", 32'(n), 32'd8);
        chk("acquisition bits", 32'(bits[7:0]), 32'hcc);
        chk("busy after acquisition", 32'(burst_busy), 32'h0);
        stop_test();
    end
endmodule : return_burst_timing_framer_tb_top
